/* File: rtoc_consts.svh */
`ifndef RTOC_CONSTS_SVH
`define RTOC_CONSTS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CODE_ADDR     4'h0
`define STATE_ADDR    4'h4
`define STATUS_ADDR   4'h8
// ----------------------------------------
// Output string characters and layout
// ----------------------------------------
`define CHR_PLUS      8'h2B
`define CHR_MINUS     8'h2D
`define CHR_ZERO      8'h30
`define CHR_E         8'h45
`define CHR_CR        8'h0D
`define CHR_LF        8'h0A
`define LAST_BYTE     4'hC
`define CR_BYTE       4'hB
`define ERR_HEAD      12'h900
`define ERR_EXP       8'h05
// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define SETTLE_CYCLES_DEF 1000
`define STATUS_RST    8'h00
`endif

/* File: rtoc_pkg.sv */
package rtoc_pkg;
    typedef enum logic [2:0] {
        free_run_code, hold_code, trigger_now_code, settled_trigger_code,
        read_right_code, read_left_code, auto_setup_code, other_code
    } code_t;
    typedef enum logic [1:0] {FREE_RUN, HOLD, TRIG_NOW, TRIG_SETTLED} trig_mode_t;
    typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_MEAS} phase_t;
    typedef struct packed {
        logic        neg;
        logic [19:0] digits;
        logic        exp_neg;
        logic [7:0]  exp;
    } result_t;
    typedef struct packed {
        logic settings_default;
        logic srq_cancel;
        logic lockout_clear;
        logic auto_setup;
    } ctl_t;
endpackage

/* File: remote_trigger_output_control.sv */
`timescale 1ns/1ps
`include "rtoc_consts.svh"
// Function
// R1: Settled trigger equals immediate trigger plus a settling delay before measuring.
// R2: Group execute trigger runs one settled measurement cycle.
// R3: In remote hold without lockout, the key trigger starts a settled cycle.
// R4: An unread key-triggered result is overwritten by the newer measurement.
// R5: Free run restarts the measurement after each bus command interruption.
// R6: Triggered measurements are not interrupted; command handshake waits for completion.
// R7: Each result is sent once, from the selected right or left display.
// R8: Errors and DC results are sent regardless of selection; DC from right.
// R9: Auto setup in remote forces special functions to zero-suffix settings.
// R10: Any code before a triggered result is sent discards it and remeasures; the hold code here only sets hold, keeping the result.
// R11: Controller sends trigger codes last and reads results before more codes.
// R12: Talker stays addressed until abort, another talk address or untalk.
// R13: Talk-only sends each result; if listener not ready, free run remeasures.
// R14: Talk-status-only repeatedly sends the status byte, clearing it per transfer.
// R15: Result string is sign, five digits, E, signed exponent, CR, LF.
// R16: Values are in fundamental units with implied point after fifth digit.
// R17: Errors use the same format above nine billion, code in last digits.
// R18: Clear acts on selected clear when listening, on device clear always.
// R19: Clear cancels pending service request, leaving code-error requests only.
// R20: Clear restores default measurement, detector, filters and special functions.
// R21: Clear selects right display, clears status, free run, and removes lockout.
// R22: After a triggered result is read, the device returns to hold.
// R23: Hold mode withholds bus output apart from service requests and polls.
// R24: Free run is the default, entered on clear and local-to-remote.
// R25: Settling delay is a parameter in clock cycles applied before sampling.
module remote_trigger_output_control #(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES_DEF
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [3:0]       adr_i,
    input  wire logic [31:0]      dat_i,
    output logic [31:0]           dat_o,
    input  wire logic             we_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    output logic                  ack_o,
    input  wire logic             remote_i,
    input  wire logic             lockout_i,
    input  wire logic             listen_i,
    input  wire logic             univ_cmd_i,
    input  wire logic             addr_cmd_i,
    input  wire logic             get_i,
    input  wire logic             sdc_i,
    input  wire logic             dcl_i,
    input  wire logic             talk_addr_i,
    input  wire logic             unaddr_i,
    input  wire logic             key_trig_i,
    input  wire logic             talk_only_switch_i,
    input  wire logic             listen_only_switch_i,
    input  wire logic             addr_all_ones_i,
    output logic                  meas_start_o,
    input  wire logic             meas_done_i,
    input  wire rtoc_pkg::result_t right_i,
    input  wire rtoc_pkg::result_t left_i,
    input  wire logic             dc_i,
    input  wire logic             err_i,
    input  wire logic [7:0]       err_code_i,
    input  wire logic [7:0]       status_set_i,
    output logic [7:0]            byte_o,
    output logic                  dav_o,
    input  wire logic             ready_i,
    output logic                  inhibit_o,
    output rtoc_pkg::ctl_t        ctl_o
);
    import rtoc_pkg::*;

    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

    trig_mode_t    mode_ff, nxt_mode;
    phase_t        phase_ff, nxt_phase;
    logic [CW-1:0] cnt_ff;
    logic          start_ff, nxt_start;
    logic          go;
    logic          ack_ff;
    logic [31:0]   dat_ff;
    logic          remote_q_ff;
    logic          right_sel_ff;
    logic          talker_ff;
    logic          fresh_ff;
    result_t       buf_ff;
    logic [3:0]    idx_ff;
    logic [7:0]    byte_ff;
    logic          dav_ff;
    logic [7:0]    status_ff;
    ctl_t          ctl_ff;

    // ----------------------------------------
    // Decoded events
    // ----------------------------------------
    logic trig, busy, clear, get_t, key_t, remote_rise, intr;
    logic code_wr, code_take, status_only, talk_only, send_req, take, sent_done;
    code_t code;

    assign trig        = (mode_ff == TRIG_NOW) || (mode_ff == TRIG_SETTLED);
    assign busy        = (phase_ff != PH_IDLE);
    assign inhibit_o   = trig && busy; // R6
    assign clear       = dcl_i || (sdc_i && listen_i); // R18
    assign get_t       = get_i && remote_i && listen_i;
    assign key_t       = key_trig_i && remote_i && !lockout_i
                         && ((mode_ff == HOLD) || (trig && !busy));
    assign remote_rise = remote_i && !remote_q_ff;
    assign intr        = (mode_ff == FREE_RUN) && (phase_ff == PH_MEAS)
                         && (univ_cmd_i || (addr_cmd_i && listen_i));
    assign code        = code_t'(dat_i[2:0]);
    assign code_wr     = cyc_i && stb_i && we_i && !ack_ff && sel_i[0]
                         && (adr_i == `CODE_ADDR);
    assign code_take   = code_wr && !inhibit_o; // R6
    assign status_only = addr_all_ones_i && talk_only_switch_i && !listen_only_switch_i;
    assign talk_only   = talk_only_switch_i && !addr_all_ones_i;
    assign send_req    = fresh_ff && (talker_ff || talk_only) && (mode_ff != HOLD); // R23
    assign take        = dav_ff && ready_i;
    assign sent_done   = take && !status_only && (idx_ff == `LAST_BYTE);

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= cyc_i && stb_i && !ack_ff && !(code_wr && inhibit_o); // R6
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_ff <= 32'h0000_0000;
        else if (cyc_i && stb_i && !we_i && !ack_ff)
        begin
            case (adr_i)
                `STATE_ADDR:
                    dat_ff <= {24'h00_0000, 1'b0, mode_ff, phase_ff, right_sel_ff,
                               fresh_ff, talker_ff};
                `STATUS_ADDR:
                    dat_ff <= {24'h00_0000, status_ff};
                default:
                    dat_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // ----------------------------------------
    // Trigger mode and measurement sequencing
    // ----------------------------------------
    always_comb
    begin
        nxt_mode = mode_ff;
        go       = 1'b0;
        if (clear || remote_rise)
        begin
            nxt_mode = FREE_RUN; // R24
            go       = 1'b1;
        end
        else if (get_t || key_t)
        begin
            nxt_mode = TRIG_SETTLED; // R2 R3
            go       = 1'b1;
        end
        else if (code_take)
        begin
            case (code)
                free_run_code:
                begin
                    nxt_mode = FREE_RUN;
                    go       = 1'b1;
                end
                hold_code:
                    nxt_mode = HOLD;
                trigger_now_code:
                begin
                    nxt_mode = TRIG_NOW;
                    go       = 1'b1;
                end
                settled_trigger_code:
                begin
                    nxt_mode = TRIG_SETTLED;
                    go       = 1'b1;
                end
                default:
                    go = trig; // R10
            endcase
        end
        else if (sent_done && trig)
            nxt_mode = HOLD; // R22 R3
    end

    always_comb
    begin
        nxt_phase = phase_ff;
        nxt_start = 1'b0;
        if (go)
        begin
            nxt_phase = (nxt_mode == TRIG_SETTLED) ? PH_SETTLE : PH_MEAS; // R1
            nxt_start = (nxt_mode != TRIG_SETTLED);
        end
        else
        begin
            case (phase_ff)
                PH_IDLE:
                    if (mode_ff == FREE_RUN)
                    begin
                        nxt_phase = PH_MEAS; // R13
                        nxt_start = 1'b1;
                    end
                PH_SETTLE:
                    if (cnt_ff == '0)
                    begin
                        nxt_phase = PH_MEAS; // R25
                        nxt_start = 1'b1;
                    end
                PH_MEAS:
                    if (intr)
                        nxt_start = 1'b1; // R5
                    else if (meas_done_i)
                        nxt_phase = PH_IDLE;
                default:
                    nxt_phase = PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_ff  <= FREE_RUN;
            phase_ff <= PH_IDLE;
            start_ff <= 1'b0;
        end
        else
        begin
            mode_ff  <= nxt_mode;
            phase_ff <= nxt_phase;
            start_ff <= nxt_start;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_ff <= '0;
        else if (go)
            cnt_ff <= SETTLE_LAST; // R25
        else if (phase_ff == PH_SETTLE && cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
    end

    assign meas_start_o = start_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            remote_q_ff <= 1'b0;
        else
            remote_q_ff <= remote_i;
    end

    // ----------------------------------------
    // Display selection, talker state, control pulses
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear)
            right_sel_ff <= 1'b1; // R7 R21
        else if (code_take && code == read_right_code)
            right_sel_ff <= 1'b1;
        else if (code_take && code == read_left_code)
            right_sel_ff <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || unaddr_i)
            talker_ff <= 1'b0; // R12
        else if (talk_addr_i)
            talker_ff <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctl_ff <= '0;
        else
        begin
            ctl_ff.settings_default <= clear; // R20
            ctl_ff.srq_cancel       <= clear; // R19
            ctl_ff.lockout_clear    <= clear; // R21
            ctl_ff.auto_setup       <= code_take && code == auto_setup_code
                                       && remote_i; // R9
        end
    end

    assign ctl_o = ctl_ff;

    // ----------------------------------------
    // Result capture
    // ----------------------------------------
    result_t src;

    always_comb
    begin
        if (err_i)
            src = '{neg: 1'b0, digits: {`ERR_HEAD, err_code_i}, exp_neg: 1'b0,
                    exp: `ERR_EXP}; // R17
        else if (dc_i || right_sel_ff)
            src = right_i; // R8
        else
            src = left_i; // R7
    end

    logic load;
    assign load = (phase_ff == PH_MEAS) && meas_done_i && !intr && !go && (idx_ff == 4'h0);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            buf_ff <= '0;
        else if (load)
            buf_ff <= src; // R4
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || go)
            fresh_ff <= 1'b0; // R10
        else if (load)
            fresh_ff <= 1'b1;
        else if (send_req && !dav_ff && !status_only)
            fresh_ff <= 1'b0; // R7
    end

    // ----------------------------------------
    // Output string and status byte sender
    // ----------------------------------------
    function automatic logic [7:0] chr(input logic [3:0] i, input result_t r);
        case (i)
            4'h1:    chr = r.neg ? `CHR_MINUS : `CHR_PLUS; // R15
            4'h2:    chr = `CHR_ZERO | {4'h0, r.digits[19:16]};
            4'h3:    chr = `CHR_ZERO | {4'h0, r.digits[15:12]};
            4'h4:    chr = `CHR_ZERO | {4'h0, r.digits[11:8]};
            4'h5:    chr = `CHR_ZERO | {4'h0, r.digits[7:4]};
            4'h6:    chr = `CHR_ZERO | {4'h0, r.digits[3:0]}; // R16
            4'h7:    chr = `CHR_E;
            4'h8:    chr = r.exp_neg ? `CHR_MINUS : `CHR_PLUS;
            4'h9:    chr = `CHR_ZERO | {4'h0, r.exp[7:4]};
            4'hA:    chr = `CHR_ZERO | {4'h0, r.exp[3:0]};
            4'hB:    chr = `CHR_CR;
            default: chr = `CHR_LF;
        endcase
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (rst_i || go)
        begin
            idx_ff  <= 4'h0;
            dav_ff  <= 1'b0;
            byte_ff <= 8'h00;
        end
        else if (status_only)
        begin
            idx_ff <= 4'h0;
            if (take)
                dav_ff <= 1'b0; // R14
            else if (!dav_ff && mode_ff != HOLD)
            begin
                dav_ff  <= 1'b1;
                byte_ff <= status_ff;
            end
        end
        else if (take)
        begin
            // A byte left over from status-only mode ends the transfer, not a string.
            if (idx_ff == `LAST_BYTE || idx_ff == 4'h0)
            begin
                dav_ff <= 1'b0;
                idx_ff <= 4'h0;
            end
            else
            begin
                byte_ff <= chr(idx_ff + 4'h1, buf_ff);
                idx_ff  <= idx_ff + 4'h1;
            end
        end
        else if (!dav_ff && send_req)
        begin
            dav_ff  <= 1'b1; // R12 R13
            idx_ff  <= 4'h1;
            byte_ff <= chr(4'h1, buf_ff);
        end
    end

    assign byte_o = byte_ff;
    assign dav_o  = dav_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_ff <= `STATUS_RST; // R21
        else if (clear || (status_only && take))
            status_ff <= `STATUS_RST | status_set_i; // R14 R21
        else
            status_ff <= status_ff | status_set_i;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence settle_end_s;
        phase_ff == PH_SETTLE && cnt_ff == '0 && !go;
    endsequence
    sequence last_accept_s;
        dav_o && ready_i && !status_only && idx_ff == `LAST_BYTE;
    endsequence

    settle_then_start_a: assert property (settle_end_s |=> meas_start_o && phase_ff == PH_MEAS) // R1
        else $error("settle end did not start measurement");
    get_settled_a: assert property (get_t && !clear && !remote_rise // R2
        |=> mode_ff == TRIG_SETTLED && phase_ff == PH_SETTLE && !meas_start_o)
        else $error("trigger message did not start settled cycle");
    key_settled_a: assert property (key_t && !clear && !remote_rise // R3
        |=> phase_ff == PH_SETTLE)
        else $error("key trigger did not start settled cycle");
    free_restart_a: assert property (intr && !go |=> meas_start_o) // R5
        else $error("interrupted free run not restarted");
    inhibit_ack_a: assert property (code_wr && inhibit_o |=> !ack_o) // R6
        else $error("code acknowledged during triggered measurement");
    clear_default_a: assert property (clear |=> mode_ff == FREE_RUN && right_sel_ff // R21
        && status_ff == (`STATUS_RST | $past(status_set_i)) && ctl_o.lockout_clear)
        else $error("clear did not restore defaults");
    string_tail_a: assert property (dav_o && idx_ff >= `CR_BYTE // R15
        |-> byte_o == ((idx_ff == `CR_BYTE) ? `CHR_CR : `CHR_LF))
        else $error("string not ended by carriage return and line feed");
    hold_after_read_a: assert property ((last_accept_s and (trig && !clear // R22
        && !remote_rise && !get_t && !key_t && !code_take)) |=> mode_ff == HOLD ##1 !dav_o)
        else $error("no return to hold after triggered readout");
    status_clear_a: assert property (status_only && dav_o && ready_i && !clear // R14
        |=> status_ff == $past(status_set_i) && !dav_o)
        else $error("status byte not cleared after transfer");
    code_discard_a: assert property (code_take && trig && code != hold_code // R10
        && !clear && !remote_rise && !get_t && !key_t |=> !fresh_ff && busy)
        else $error("code after trigger did not remeasure");

endmodule // remote_trigger_output_control

/* File: listener_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Listener on the far side of the byte output
// ----------------------------------------
module listener_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic stall_i,
    output logic      ready_o
);
    logic [1:0] phase_ff;

    // Ready drops one cycle in three, so the talker has to hold some bytes.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_ff <= 2'h0;
        end
        else
        begin
            phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
        end
    end

    assign ready_o = !stall_i && !rst_i && (phase_ff != 2'h2);
endmodule // listener_model

/* File: remote_trigger_output_control_tb.sv */
`timescale 1ns/1ps
`include "rtoc_consts.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
`define PULSE(s) begin @(posedge clk_i); s <= 1'b1; t_mark = cyc_n; \
    @(posedge clk_i); s <= 1'b0; end
module remote_trigger_output_control_tb;
    import rtoc_pkg::*;
    localparam int S = 8;
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, meas_start_o, dav_o, ready_i, inhibit_o, meas_done_i = 1'b0;
    logic remote_i = 1'b1, lockout_i = 1'b0, listen_i = 1'b0, univ_i = 1'b0, acmd_i = 1'b0;
    logic get_i = 1'b0, sdc_i = 1'b0, dcl_i = 1'b0, talk_i = 1'b0, unaddr_i = 1'b0;
    logic key_i = 1'b0, tos_i = 1'b0, los_i = 1'b0, ones_i = 1'b0, dc_i = 1'b0, err_i = 1'b0;
    logic [7:0] err_code_i = 8'h0, status_i = 8'h0, byte_o, eb;
    result_t right_i = '0, left_i = '0, rr;
    ctl_t ctl_o;
    logic [7:0] exp_q[$];
    logic [31:0] lfsr = 32'h39A952F8;
    int err_count = 0, n_compared = 0, cyc_n = 0, t_mark = 0, t_start = 0, ts = 0;
    int dp_cnt = 0, clr_cnt = 0, au_cnt = 0;

    remote_trigger_output_control #(.SETTLE_CYCLES(S)) i_remote_trigger_output_control (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .remote_i(remote_i), .lockout_i(lockout_i), .listen_i(listen_i),
        .univ_cmd_i(univ_i), .addr_cmd_i(acmd_i), .get_i(get_i), .sdc_i(sdc_i),
        .dcl_i(dcl_i), .talk_addr_i(talk_i), .unaddr_i(unaddr_i), .key_trig_i(key_i),
        .talk_only_switch_i(tos_i), .listen_only_switch_i(los_i),
        .addr_all_ones_i(ones_i), .meas_start_o(meas_start_o), .meas_done_i(meas_done_i),
        .right_i(right_i), .left_i(left_i), .dc_i(dc_i), .err_i(err_i),
        .err_code_i(err_code_i), .status_set_i(status_i), .byte_o(byte_o), .dav_o(dav_o),
        .ready_i(ready_i), .inhibit_o(inhibit_o), .ctl_o(ctl_o));

    listener_model i_listener_model (
        .clk_i(clk_i), .rst_i(rst_i), .stall_i(1'b0), .ready_o(ready_i));

    always #2.5 clk_i = ~clk_i;

    // ----------------------------------------
    // Measurement datapath stand-in and event log
    // ----------------------------------------
    // A start always restarts the 20-cycle count, as a real restart would.
    always @(posedge clk_i)
    begin
        cyc_n++;
        meas_done_i <= 1'b0;
        if (meas_start_o === 1'b1)
        begin
            t_start = cyc_n;
            dp_cnt = 20;
        end
        else if (dp_cnt > 0)
        begin
            dp_cnt--;
            if (dp_cnt == 0) meas_done_i <= 1'b1;
        end
        if ((ctl_o.settings_default & ctl_o.srq_cancel & ctl_o.lockout_clear) === 1'b1) clr_cnt++;
        if (ctl_o.auto_setup === 1'b1) au_cnt++;
        if (dav_o === 1'b1 && ready_i === 1'b1 && exp_q.size() > 0)
        begin
            eb = exp_q.pop_front();
            `CHK(byte_o, eb)
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic finish_test();
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 3000);
        if (n >= 3000) begin err_count++; finish_test(); end
        rd = dat_o;
        t_mark = cyc_n;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic code(input code_t c);
        wb(1'b1, `CODE_ADDR, {29'h0, c});
    endtask

    task automatic gap(input int lo, input int hi);
        `CHK((t_start - t_mark >= lo && t_start - t_mark <= hi), 1'b1)
    endtask

    function automatic result_t new_res();
        result_t r;
        r = '0;
        for (int i = 0; i < 5; i++)
        begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            r.digits[i*4 +: 4] = 4'(lfsr[7:0] % 10);
        end
        r.neg = lfsr[3];
        r.exp_neg = lfsr[4];
        r.exp = {6'h0, lfsr[9:8]};
        return r;
    endfunction

    task automatic expect_res(input result_t r);
        exp_q.push_back(r.neg ? `CHR_MINUS : `CHR_PLUS);
        for (int i = 4; i >= 0; i--) exp_q.push_back(`CHR_ZERO | {4'h0, r.digits[i*4 +: 4]});
        exp_q.push_back(`CHR_E);
        exp_q.push_back(r.exp_neg ? `CHR_MINUS : `CHR_PLUS);
        exp_q.push_back(`CHR_ZERO | {4'h0, r.exp[7:4]});
        exp_q.push_back(`CHR_ZERO | {4'h0, r.exp[3:0]});
        exp_q.push_back(`CHR_CR);
        exp_q.push_back(`CHR_LF);
    endtask

    task automatic wait_empty();
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 600)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 600) begin err_count++; finish_test(); end
        tos_i <= 1'b0;
        ones_i <= 1'b0;
        tick(3);
        `CHK(dav_o, 1'b0)
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        right_i <= new_res();
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(30);
        wb(1'b0, `STATE_ADDR, 32'h0);
        `CHK(rd[6:5], 2'h0)
        `CHK(rd[2], 1'b1)
        wb(1'b0, 4'hC, 32'h0);
        `CHK(rd, 32'h0)
        tick(7);
        `PULSE(univ_i)
        tick(4);
        gap(0, 3);
        listen_i <= 1'b1;
        tick(9);
        `PULSE(acmd_i)
        tick(4);
        gap(0, 3);
        listen_i <= 1'b0;
        code(auto_setup_code);
        tick(3);
        `CHK(au_cnt, 1)
        code(hold_code);
        expect_res(right_i);
        code(settled_trigger_code);
        tick(S + 4);
        gap(S - 1, S + 3);
        `CHK(inhibit_o, 1'b1)
        ts = t_start;
        `PULSE(univ_i)
        tick(3);
        `CHK(t_start, ts)
        tick(25);
        wb(1'b0, `STATE_ADDR, 32'h0);
        `CHK(rd[1], 1'b1)
        `PULSE(talk_i)
        wait_empty();
        wb(1'b0, `STATE_ADDR, 32'h0);
        `CHK(rd[6:5], 2'h1)
        code(read_left_code);
        rr = new_res();
        left_i <= rr;
        expect_res(rr);
        code(trigger_now_code);
        tick(4);
        gap(0, 3);
        wait_empty();
        dc_i <= 1'b1;
        rr = new_res();
        right_i <= rr;
        expect_res(rr);
        code(trigger_now_code);
        wait_empty();
        dc_i <= 1'b0;
        err_i <= 1'b1;
        err_code_i <= 8'h37;
        expect_res(result_t'{1'b0, {`ERR_HEAD, 8'h37}, 1'b0, `ERR_EXP});
        code(trigger_now_code);
        wait_empty();
        err_i <= 1'b0;
        `PULSE(unaddr_i)
        code(settled_trigger_code);
        tick(S + 4);
        code(read_right_code);
        wb(1'b0, `STATE_ADDR, 32'h0);
        `CHK(rd[1], 1'b0)
        tick(S + 2);
        `CHK((t_start > t_mark), 1'b1)
        expect_res(right_i);
        `PULSE(talk_i)
        wait_empty();
        `PULSE(unaddr_i)
        `PULSE(key_i)
        tick(S + 6);
        gap(S - 1, S + 3);
        tick(22);
        right_i <= new_res();
        `PULSE(key_i)
        tick(S + 28);
        expect_res(right_i);
        `PULSE(talk_i)
        wait_empty();
        lockout_i <= 1'b1;
        ts = t_start;
        `PULSE(key_i)
        tick(S + 6);
        `CHK(t_start, ts)
        lockout_i <= 1'b0;
        listen_i <= 1'b1;
        rr = new_res();
        right_i <= rr;
        expect_res(rr);
        `PULSE(get_i)
        tick(S + 6);
        gap(S - 1, S + 3);
        wait_empty();
        listen_i <= 1'b0;
        `PULSE(unaddr_i)
        remote_i <= 1'b0;
        tick(3);
        remote_i <= 1'b1;
        tick(3);
        wb(1'b0, `STATE_ADDR, 32'h0);
        `CHK(rd[6:5], 2'h0)
        code(read_left_code);
        @(posedge clk_i);
        status_i <= 8'h01;
        @(posedge clk_i);
        status_i <= 8'h00;
        wb(1'b0, `STATUS_ADDR, 32'h0);
        `CHK(rd[7:0], 8'h01)
        `PULSE(sdc_i)
        tick(3);
        `CHK(clr_cnt, 0)
        listen_i <= 1'b1;
        `PULSE(sdc_i)
        tick(3);
        `CHK(clr_cnt, 1)
        wb(1'b0, `STATE_ADDR, 32'h0);
        `CHK({rd[6:5], rd[2]}, 3'h1)
        wb(1'b0, `STATUS_ADDR, 32'h0);
        `CHK(rd[7:0], `STATUS_RST)
        listen_i <= 1'b0;
        `PULSE(dcl_i)
        tick(3);
        `CHK(clr_cnt, 2)
        @(posedge clk_i);
        status_i <= 8'h5A;
        @(posedge clk_i);
        status_i <= 8'h00;
        exp_q.push_back(8'h5A);
        exp_q.push_back(8'h00);
        tos_i <= 1'b1;
        ones_i <= 1'b1;
        wait_empty();
        expect_res(right_i);
        tos_i <= 1'b1;
        wait_empty();
        wb(1'b0, `STATUS_ADDR, 32'h0);
        `CHK(rd[7:0], 8'h00)
        finish_test();
    end
endmodule // remote_trigger_output_control_tb
